// ==== zab_pkg.sv ====
// shared constants and types for the air generator register bank
package zab_pkg;
    // register spaces of a request
    typedef enum logic [1:0] {
        ZAB_SPACE_COIL,
        ZAB_SPACE_DISCRETE,
        ZAB_SPACE_HOLDING,
        ZAB_SPACE_INPUT
    } zab_space_type;

    // coil addresses
    localparam logic [15:0] ZAB_COIL_RESTART_WARN = 16'h0000;
    localparam logic [15:0] ZAB_COIL_PUMP_STANDBY = 16'h0001;
    localparam logic [15:0] ZAB_COIL_SERVICE_CLEAR = 16'h0002;
    localparam logic [15:0] ZAB_COIL_RESTART_LATCH = 16'h0003;
    localparam logic [15:0] ZAB_COIL_PROC_RESTART = 16'h0004;
    // discrete inputs: service due at 0, six pin alerts at 1 to 6
    localparam logic [15:0] ZAB_DISC_LAST = 16'h0006;
    localparam int ZAB_PIN_ALERTS = 6;
    // holding register
    localparam logic [15:0] ZAB_HOLD_NODE_ADDR = 16'h0000;
    localparam logic [15:0] ZAB_NODE_ADDR_MIN = 16'h0001;
    localparam logic [15:0] ZAB_NODE_ADDR_MAX = 16'h00F7;
    localparam logic [15:0] ZAB_NODE_ADDR_RESET = 16'h0001;
    // input register pair starts
    localparam logic [15:0] ZAB_IN_RESERVOIR = 16'h0000;
    localparam logic [15:0] ZAB_IN_OUTLET = 16'h0002;
    localparam logic [15:0] ZAB_IN_SCRUB_TEMP = 16'h0004;
    localparam logic [15:0] ZAB_IN_ENCL_TEMP = 16'h0006;
    localparam logic [15:0] ZAB_IN_PUMP_DUTY = 16'h0008;
    localparam logic [15:0] ZAB_IN_HEAT_DUTY = 16'h000A;
    localparam logic [15:0] ZAB_IN_SERVICE_HRS = 16'h000C;
    localparam logic [15:0] ZAB_IN_REF_VOLT = 16'h000E;
    localparam logic [15:0] ZAB_IN_MODEL = 16'h001E;
    localparam logic [15:0] ZAB_IN_SERIAL = 16'h0020;
    localparam logic [15:0] ZAB_IN_FW_PART = 16'h0022;
    localparam logic [15:0] ZAB_IN_FW_VERSION = 16'h0024;
    // float conversion constants
    localparam logic [7:0] ZAB_FLOAT_BIAS = 8'h7F;
    localparam int ZAB_MANT_BITS = 23;
    // time base: one operating hour
    localparam longint ZAB_HOUR_SECONDS = 3600;
    localparam longint ZAB_CLK_HZ = 40000000;
    localparam longint ZAB_HOUR_CYCLES = ZAB_HOUR_SECONDS * ZAB_CLK_HZ;

    typedef struct packed {
        logic write;
        zab_space_type space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } zab_req_type;

    typedef struct packed {
        logic error;
        logic [15:0] data;
    } zab_rsp_type;

    typedef struct packed {
        logic [31:0] reservoir_pressure;
        logic [31:0] outlet_pressure;
        logic [31:0] scrubber_temperature;
        logic [31:0] enclosure_temperature;
        logic [31:0] pump_duty;
        logic [31:0] heater_duty;
        logic [31:0] reference_voltage;
    } zab_meas_type;
endpackage

// ==== zab_register_bank.sv ====
// register bank of the zero air generator controller
//
// Notes on behaviour
// R1: restart warning coil reads 1 after every processor restart.
// R2: master writing 0 to restart warning clears it at once, latched or not.
// R3: unlatched restart warning clears itself when warm-up ends.
// R4: latched restart warning never self-clears; only a master write of 0 clears it.
// R5: writing 1 to pump standby coil stops pump, hydrocarbon heater keeps running.
// R6: writing 0 to pump standby coil restarts the pump.
// R7: service timer counts down operating hours, read as value in hours.
// R8: service timer reaching zero sets the service due warning input.
// R9: writing 1 to service clear coil clears warning and restarts timer.
// R10: node address holding register accepts 1 to 247 only, resets to 1.
// R11: new node address takes effect immediately.
// R12: ethernet masters should preferably set node address to 1.
// R13: seven read-only warning inputs at 0 to 6, shutdowns at 4 and 5.
// R14: pump and heater duty are float fractions at input registers 8, 10.
// R15: measured values are 32-bit floats at even input addresses 0 to 14.
// R16: reference voltage in millivolts is a float at input register 14.
// R17: each 32-bit value spans two consecutive 16-bit input registers.
`timescale 1ns/1ps
module zab_register_bank
    import zab_pkg::*;
#(
    parameter longint HOUR_CYCLES = ZAB_HOUR_CYCLES,
    parameter int HOUR_CNT_W = 38,
    parameter logic [15:0] SERVICE_HOURS = 16'h03E8,
    parameter logic [31:0] MODEL_WORD = 32'h00001234,
    parameter logic [31:0] SERIAL_WORD = 32'h00005678,
    parameter logic [31:0] FW_PART_WORD = 32'h00009ABC,
    parameter logic [31:0] FW_VERSION_WORD = 32'h3F800000
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire zab_req_type REQ,
    output zab_rsp_type RSP,
    output logic RSP_VALID,
    input wire zab_meas_type MEAS,
    input wire logic [ZAB_PIN_ALERTS-1:0] ALERT_PINS,
    input wire logic WARMUP_DONE_PIN,
    output logic PUMP_ENABLE,
    output logic HEATER_ENABLE,
    output logic PROCESSOR_RESTART,
    output logic [15:0] NODE_ADDRESS
);
    // unsigned 16-bit integer to single-precision float
    function automatic logic [31:0] zab_to_float(input logic [15:0] n);
        logic [31:0] shifted;
        int msb;
        shifted = 32'h00000000;
        msb = 0;
        for (int i = 0; i < 16; i++) begin
            if (n[i]) begin
                msb = i;
            end
        end
        if (n == 16'h0000) begin
            return 32'h00000000;
        end
        shifted = {16'h0000, n} << (ZAB_MANT_BITS - msb);
        return {1'b0, 8'(ZAB_FLOAT_BIAS + 8'(msb)), shifted[ZAB_MANT_BITS-1:0]};
    endfunction

    // select half of a 32-bit value by the odd address bit
    function automatic logic [15:0] zab_half(input logic [31:0] v, input logic upper);
        return upper ? v[31:16] : v[15:0];
    endfunction

    logic [ZAB_PIN_ALERTS:0] sync_a;
    logic [ZAB_PIN_ALERTS:0] sync_b;
    logic warmup_prev;
    logic warmup_rise;
    logic [ZAB_PIN_ALERTS-1:0] alerts;
    logic restart_warning;
    logic restart_latch;
    logic pump_standby;
    logic service_due;
    logic [15:0] service_hours;
    logic [HOUR_CNT_W-1:0] hour_cnt;
    logic hour_tick;
    logic wr;
    logic rd;
    logic coil_wr_restart;
    logic coil_wr_standby;
    logic coil_wr_clear;
    logic coil_wr_latch;
    logic coil_wr_proc;
    logic node_wr;
    logic node_ok;
    logic next_standby;
    logic [31:0] in_value;
    logic in_hit;

    assign wr = REQ_VALID && REQ.write;
    assign rd = REQ_VALID && !REQ.write;
    assign coil_wr_restart = wr && REQ.space == ZAB_SPACE_COIL && REQ.addr == ZAB_COIL_RESTART_WARN;
    assign coil_wr_standby = wr && REQ.space == ZAB_SPACE_COIL && REQ.addr == ZAB_COIL_PUMP_STANDBY;
    assign coil_wr_clear = wr && REQ.space == ZAB_SPACE_COIL && REQ.addr == ZAB_COIL_SERVICE_CLEAR;
    assign coil_wr_latch = wr && REQ.space == ZAB_SPACE_COIL && REQ.addr == ZAB_COIL_RESTART_LATCH;
    assign coil_wr_proc = wr && REQ.space == ZAB_SPACE_COIL && REQ.addr == ZAB_COIL_PROC_RESTART;
    assign node_wr = wr && REQ.space == ZAB_SPACE_HOLDING && REQ.addr == ZAB_HOLD_NODE_ADDR;
    assign node_ok = REQ.wdata >= ZAB_NODE_ADDR_MIN && REQ.wdata <= ZAB_NODE_ADDR_MAX;
    assign warmup_rise = sync_b[ZAB_PIN_ALERTS] && !warmup_prev;
    assign alerts = sync_b[ZAB_PIN_ALERTS-1:0];
    assign hour_tick = hour_cnt == HOUR_CNT_W'(HOUR_CYCLES - 1);
    assign next_standby = coil_wr_standby ? REQ.wdata[0] : pump_standby;

    // pin synchronisers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync_a <= '0;
            sync_b <= '0;
            warmup_prev <= 1'b0;
        end else begin
            sync_a <= {WARMUP_DONE_PIN, ALERT_PINS};
            sync_b <= sync_a;
            warmup_prev <= sync_b[ZAB_PIN_ALERTS];
        end
    end

    // restart warning and its latch
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            restart_warning <= 1'b1; // [R1]
            restart_latch <= 1'b0;
        end else begin
            if (coil_wr_latch) begin
                restart_latch <= REQ.wdata[0];
            end
            if (coil_wr_restart) begin
                restart_warning <= REQ.wdata[0]; // [R2]
            end else if (warmup_rise && !restart_latch) begin
                restart_warning <= 1'b0; // [R3] [R4]
            end
        end
    end

    // pump standby; heater stays on in standby
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pump_standby <= 1'b0;
            PUMP_ENABLE <= 1'b1;
            HEATER_ENABLE <= 1'b1;
        end else begin
            pump_standby <= next_standby;
            PUMP_ENABLE <= !next_standby; // [R5] [R6]
            HEATER_ENABLE <= 1'b1; // [R5]
        end
    end

    // hour divider, runs only while the pump operates
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hour_cnt <= '0;
        end else if (!pump_standby) begin
            hour_cnt <= hour_tick ? '0 : hour_cnt + 1'b1;
        end
    end

    // service interval countdown and reminder
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            service_hours <= SERVICE_HOURS;
            service_due <= 1'b0;
        end else if (coil_wr_clear && REQ.wdata[0]) begin
            service_hours <= SERVICE_HOURS; // [R9]
            service_due <= 1'b0; // [R9]
        end else if (hour_tick && !pump_standby && service_hours != 16'h0000) begin
            service_hours <= service_hours - 16'h0001; // [R7]
            if (service_hours == 16'h0001) begin
                service_due <= 1'b1; // [R8]
            end
        end
    end

    // node address, applied without restart
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            NODE_ADDRESS <= ZAB_NODE_ADDR_RESET; // [R10]
        end else if (node_wr && node_ok) begin
            NODE_ADDRESS <= REQ.wdata; // [R10] [R11]
        end
    end

    // processor restart request pulse
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PROCESSOR_RESTART <= 1'b0;
        end else begin
            PROCESSOR_RESTART <= coil_wr_proc && REQ.wdata[0];
        end
    end

    // input register pair lookup
    always_comb begin
        in_hit = 1'b1;
        in_value = 32'h00000000;
        if ({REQ.addr[15:1], 1'b0} == ZAB_IN_RESERVOIR) begin
            in_value = MEAS.reservoir_pressure; // [R15] [R17]
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_OUTLET) begin
            in_value = MEAS.outlet_pressure;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_SCRUB_TEMP) begin
            in_value = MEAS.scrubber_temperature;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_ENCL_TEMP) begin
            in_value = MEAS.enclosure_temperature;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_PUMP_DUTY) begin
            in_value = MEAS.pump_duty; // [R14]
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_HEAT_DUTY) begin
            in_value = MEAS.heater_duty; // [R14]
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_SERVICE_HRS) begin
            in_value = zab_to_float(service_hours); // [R7]
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_REF_VOLT) begin
            in_value = MEAS.reference_voltage; // [R16]
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_MODEL) begin
            in_value = MODEL_WORD;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_SERIAL) begin
            in_value = SERIAL_WORD;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_FW_PART) begin
            in_value = FW_PART_WORD;
        end else if ({REQ.addr[15:1], 1'b0} == ZAB_IN_FW_VERSION) begin
            in_value = FW_VERSION_WORD;
        end else begin
            in_hit = 1'b0;
        end
    end

    // request answer, one cycle after the request
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RSP_VALID <= 1'b0;
            RSP <= '0;
        end else begin
            RSP_VALID <= REQ_VALID;
            RSP.data <= 16'h0000;
            RSP.error <= 1'b0;
            if (REQ_VALID) begin
                if (REQ.space == ZAB_SPACE_COIL) begin
                    if (REQ.addr == ZAB_COIL_RESTART_WARN) begin
                        RSP.data[0] <= restart_warning;
                    end else if (REQ.addr == ZAB_COIL_PUMP_STANDBY) begin
                        RSP.data[0] <= pump_standby;
                    end else if (REQ.addr == ZAB_COIL_RESTART_LATCH) begin
                        RSP.data[0] <= restart_latch;
                    end else if (REQ.addr > ZAB_COIL_PROC_RESTART) begin
                        RSP.error <= 1'b1;
                    end
                end else if (REQ.space == ZAB_SPACE_DISCRETE) begin
                    if (REQ.write || REQ.addr > ZAB_DISC_LAST) begin
                        RSP.error <= 1'b1; // [R13]
                    end else if (REQ.addr == 16'h0000) begin
                        RSP.data[0] <= service_due; // [R8]
                    end else begin
                        RSP.data[0] <= alerts[REQ.addr[2:0] - 3'h1]; // [R13]
                    end
                end else if (REQ.space == ZAB_SPACE_HOLDING) begin
                    if (REQ.addr != ZAB_HOLD_NODE_ADDR || (REQ.write && !node_ok)) begin
                        RSP.error <= 1'b1; // [R10]
                    end else begin
                        RSP.data <= REQ.write ? REQ.wdata : NODE_ADDRESS;
                    end
                end else begin
                    if (REQ.write || !in_hit) begin
                        RSP.error <= 1'b1;
                    end else begin
                        RSP.data <= zab_half(in_value, REQ.addr[0]); // [R17]
                    end
                end
            end
        end
    end

    property p_restart_set;
        @(posedge CLK) $past(!RST_N) && RST_N |-> restart_warning;
    endproperty
    a_restart_set: assert property (p_restart_set) else $error("restart warning not set"); // [R1]

    property p_write_clear;
        @(posedge CLK) disable iff (!RST_N)
        coil_wr_restart && !REQ.wdata[0] |=> !restart_warning;
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("warning write 0 ignored"); // [R2]

    property p_auto_clear;
        @(posedge CLK) disable iff (!RST_N)
        warmup_rise && !restart_latch && !coil_wr_restart |=> !restart_warning;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("warning not auto cleared"); // [R3]

    property p_latched_hold;
        @(posedge CLK) disable iff (!RST_N)
        restart_latch && restart_warning && !coil_wr_restart |=> restart_warning;
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("latched warning dropped"); // [R4]

    property p_standby;
        @(posedge CLK) disable iff (!RST_N)
        coil_wr_standby && REQ.wdata[0] |=> !PUMP_ENABLE && HEATER_ENABLE;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered"); // [R5]

    property p_resume;
        @(posedge CLK) disable iff (!RST_N)
        coil_wr_standby && !REQ.wdata[0] |=> PUMP_ENABLE ##1 (PUMP_ENABLE || pump_standby);
    endproperty
    a_resume: assert property (p_resume) else $error("pump not resumed"); // [R6]

    property p_due_set;
        @(posedge CLK) disable iff (!RST_N)
        hour_tick && !pump_standby && service_hours == 16'h0001 && !coil_wr_clear
        |=> service_due && service_hours == 16'h0000;
    endproperty
    a_due_set: assert property (p_due_set) else $error("service due not set"); // [R8]

    property p_service_clear;
        @(posedge CLK) disable iff (!RST_N)
        coil_wr_clear && REQ.wdata[0] |=> !service_due && service_hours == SERVICE_HOURS;
    endproperty
    a_service_clear: assert property (p_service_clear) else $error("service clear failed"); // [R9]

    property p_node_range;
        @(posedge CLK) disable iff (!RST_N)
        node_wr && !node_ok |=> $stable(NODE_ADDRESS) && RSP.error && RSP_VALID;
    endproperty
    a_node_range: assert property (p_node_range) else $error("bad node address taken"); // [R10]

    property p_node_now;
        @(posedge CLK) disable iff (!RST_N)
        node_wr && node_ok |=> NODE_ADDRESS == $past(REQ.wdata);
    endproperty
    a_node_now: assert property (p_node_now) else $error("node address not applied"); // [R11]

    property p_in_pair;
        @(posedge CLK) disable iff (!RST_N)
        rd && REQ.space == ZAB_SPACE_INPUT && in_hit
        |=> RSP_VALID && !RSP.error && RSP.data == zab_half($past(in_value), $past(REQ.addr[0]));
    endproperty
    a_in_pair: assert property (p_in_pair) else $error("input register read wrong"); // [R17]

    property p_disc_refuse;
        @(posedge CLK) disable iff (!RST_N)
        REQ_VALID && REQ.space == ZAB_SPACE_DISCRETE && (REQ.write || REQ.addr > ZAB_DISC_LAST)
        |=> RSP_VALID && RSP.error;
    endproperty
    a_disc_refuse: assert property (p_disc_refuse) else $error("discrete refusal missing"); // [R13]

    property p_hours_count;
        @(posedge CLK) disable iff (!RST_N)
        hour_tick && !pump_standby && service_hours != 16'h0000 && !(coil_wr_clear && REQ.wdata[0])
        |=> service_hours == $past(service_hours) - 16'h0001;
    endproperty
    a_hours_count: assert property (p_hours_count) else $error("service hours not counted"); // [R7]
endmodule

// ==== zab_master_model.sv ====
// bus master model that issues register requests to the bank
`timescale 1ns/1ps
module zab_master_model
    import zab_pkg::*;
(
    input wire logic clk,
    output logic req_valid,
    output zab_req_type req,
    input wire zab_rsp_type rsp,
    input wire logic rsp_valid
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // one strobed request, answer taken in the following cycle
    task automatic access(input logic wr, input zab_space_type sp, input logic [15:0] addr,
        input logic [15:0] wdata, input int idle, output zab_rsp_type got, output logic seen);
        repeat (idle) @(posedge clk);
        @(posedge clk);
        #2;
        req_valid = 1'b1;
        req = {wr, sp, addr, wdata};
        @(posedge clk);
        #2;
        req_valid = 1'b0;
        // released lines show a changed pattern
        req = {~wr, sp, ~addr, ~wdata};
        seen = rsp_valid;
        got = rsp;
    endtask

    // network master settles on node address one
    task automatic network_setup(output zab_rsp_type got, output logic seen);
        access(1'b1, ZAB_SPACE_HOLDING, ZAB_HOLD_NODE_ADDR, 16'h0001, 0, got, seen);
    endtask
endmodule

// ==== tb_zero_air_modbus_register_bank.sv ====
// self-checking bench of the air generator register bank
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module tb_zero_air_modbus_register_bank
    import zab_pkg::*;
;
    // identity words, values arbitrary
    localparam logic [31:0] ID_MODEL = 32'h0000A5A5;
    localparam logic [31:0] ID_SERIAL = 32'h00003C3C;
    localparam logic [31:0] ID_PART = 32'h00001111;
    localparam logic [31:0] ID_VERSION = 32'h40400000;
    logic clk = 1'b0;
    logic rst_n;
    logic req_valid;
    zab_req_type req;
    zab_rsp_type rsp;
    logic rsp_valid;
    zab_meas_type meas;
    logic [ZAB_PIN_ALERTS-1:0] alerts;
    logic warmup;
    logic pump_en;
    logic heater_en;
    logic proc_restart;
    logic [15:0] node_addr;
    zab_rsp_type got;
    logic seen;
    logic [15:0] exp_addr;
    logic [15:0] vals[9] = '{16'h0000, 16'h0001, 16'h00F7, 16'h00F8, 16'hFFFF, 0, 0, 0, 0};
    int pairs[11] = '{0, 2, 4, 6, 8, 10, 14, 30, 32, 34, 36};
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    zab_register_bank #(.HOUR_CYCLES(4), .SERVICE_HOURS(16'h0002), .MODEL_WORD(ID_MODEL),
        .SERIAL_WORD(ID_SERIAL), .FW_PART_WORD(ID_PART), .FW_VERSION_WORD(ID_VERSION)) u_dut (
        .CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req), .RSP(rsp),
        .RSP_VALID(rsp_valid), .MEAS(meas), .ALERT_PINS(alerts), .WARMUP_DONE_PIN(warmup),
        .PUMP_ENABLE(pump_en), .HEATER_ENABLE(heater_en), .PROCESSOR_RESTART(proc_restart),
        .NODE_ADDRESS(node_addr));

    zab_master_model u_master (.clk(clk), .req_valid(req_valid), .req(req), .rsp(rsp),
        .rsp_valid(rsp_valid));

    // expected word of an input register
    function automatic logic [15:0] word_of(input int a);
        logic [31:0] v;
        case (a >> 1)
            0: v = meas.reservoir_pressure;
            1: v = meas.outlet_pressure;
            2: v = meas.scrubber_temperature;
            3: v = meas.enclosure_temperature;
            4: v = meas.pump_duty;
            5: v = meas.heater_duty;
            7: v = meas.reference_voltage;
            15: v = ID_MODEL;
            16: v = ID_SERIAL;
            17: v = ID_PART;
            18: v = ID_VERSION;
            default: v = 32'h0;
        endcase
        return a[0] ? v[31:16] : v[15:0];
    endfunction

    function automatic logic [31:0] hours_float(input int h);
        return (h == 0) ? 32'h0 : (h == 1) ? 32'h3F800000 : 32'h40000000;
    endfunction

    task automatic xfer(input logic wr, input zab_space_type sp, input logic [15:0] a,
        input logic [15:0] d);
        u_master.access(wr, sp, a, d, int'($urandom_range(0, 2)), got, seen);
        `CHK(seen, 1'b1)
    endtask

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        rst_n = 1'b0;
        alerts = '0;
        warmup = 1'b0;
        meas = '0;
        void'($urandom(57));
        meas = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        repeat (5) @(posedge clk);
        #2 rst_n = 1'b1;
        xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
        `CHK(got.data[0], 1'b1)
        `CHK(node_addr, ZAB_NODE_ADDR_RESET)
        `CHK({pump_en, heater_en}, 2'b11)
        warmup = 1'b1;
        repeat (6) @(posedge clk);
        xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
        `CHK(got.data[0], 1'b0)
        for (int l = 0; l < 2; l++) begin
            xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_RESTART_LATCH, 16'(l));
            xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h1);
            xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
            xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
            `CHK(got.data[0], 1'b0)
        end
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_PROC_RESTART, 16'h1);
        `CHK(proc_restart, 1'b1)
        // restart in mid-run, then a latched warning across warm-up
        warmup = 1'b0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #2 rst_n = 1'b1;
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_RESTART_LATCH, 16'h1);
        warmup = 1'b1;
        repeat (6) @(posedge clk);
        xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
        `CHK(got.data[0], 1'b1)
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
        xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_RESTART_WARN, 16'h0);
        `CHK(got.data[0], 1'b0)
        // standby freezes the service timer, which has run out by now
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_PUMP_STANDBY, 16'h1);
        `CHK({pump_en, heater_en}, 2'b01)
        xfer(1'b0, ZAB_SPACE_COIL, ZAB_COIL_PUMP_STANDBY, 16'h0);
        `CHK(got.data[0], 1'b1)
        xfer(1'b0, ZAB_SPACE_DISCRETE, 16'h0, 16'h0);
        `CHK(got.data[0], 1'b1)
        xfer(1'b0, ZAB_SPACE_INPUT, ZAB_IN_SERVICE_HRS + 16'h1, 16'h0);
        `CHK(got.data, 16'(hours_float(0) >> 16))
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_SERVICE_CLEAR, 16'h1);
        xfer(1'b0, ZAB_SPACE_DISCRETE, 16'h0, 16'h0);
        `CHK(got.data[0], 1'b0)
        for (int j = 0; j < 2; j++) begin
            xfer(1'b0, ZAB_SPACE_INPUT, ZAB_IN_SERVICE_HRS + 16'(j), 16'h0);
            `CHK(got.data, 16'(hours_float(2) >> (16 * j)))
        end
        xfer(1'b1, ZAB_SPACE_COIL, ZAB_COIL_PUMP_STANDBY, 16'h0);
        `CHK(pump_en, 1'b1)
        repeat (20) @(posedge clk);
        xfer(1'b0, ZAB_SPACE_DISCRETE, 16'h0, 16'h0);
        `CHK(got.data[0], 1'b1)
        // node address: corners then random legal values
        for (int i = 5; i < 9; i++) vals[i] = 16'($urandom_range(1, 247));
        exp_addr = ZAB_NODE_ADDR_RESET;
        foreach (vals[i]) begin
            xfer(1'b1, ZAB_SPACE_HOLDING, ZAB_HOLD_NODE_ADDR, vals[i]);
            `CHK(got.error, !(vals[i] >= 16'h0001 && vals[i] <= 16'h00F7))
            if (vals[i] >= 16'h0001 && vals[i] <= 16'h00F7) exp_addr = vals[i];
            `CHK(node_addr, exp_addr)
        end
        xfer(1'b0, ZAB_SPACE_HOLDING, ZAB_HOLD_NODE_ADDR, 16'h0);
        `CHK(got.data, exp_addr)
        xfer(1'b0, ZAB_SPACE_HOLDING, 16'h0001, 16'h0);
        `CHK(got.error, 1'b1)
        for (int r = 0; r < 2; r++) begin
            alerts = 6'($urandom);
            repeat (4) @(posedge clk);
            #2;
            for (int i = 0; i < ZAB_PIN_ALERTS; i++) begin
                xfer(1'b0, ZAB_SPACE_DISCRETE, 16'(i + 1), 16'h0);
                `CHK(got.data[0], alerts[i])
            end
        end
        xfer(1'b1, ZAB_SPACE_DISCRETE, 16'h0004, 16'h1);
        `CHK(got.error, 1'b1)
        xfer(1'b0, ZAB_SPACE_DISCRETE, ZAB_DISC_LAST + 16'h1, 16'h0);
        `CHK(got.error, 1'b1)
        foreach (pairs[k]) begin
            for (int j = 0; j < 2; j++) begin
                xfer(1'b0, ZAB_SPACE_INPUT, 16'(pairs[k] + j), 16'h0);
                `CHK(got.data, word_of(pairs[k] + j))
            end
        end
        xfer(1'b1, ZAB_SPACE_INPUT, ZAB_IN_PUMP_DUTY, 16'h1);
        `CHK(got.error, 1'b1)
        xfer(1'b0, ZAB_SPACE_INPUT, 16'h0010, 16'h0);
        `CHK(got.error, 1'b1)
        u_master.network_setup(got, seen);
        `CHK(node_addr, 16'h0001)
        close_out();
    end
endmodule
